/* hdl/bpr_top.sv */
// Purpose: per-bank open/idle tracking, precharge, auto precharge, refresh
// Assumes: command pins come from the controller's clock domain via pins
// Notes: data output enable is held off during refresh, not during precharge
`default_nettype none

// What this block does
// - precharge closes row, bank ready after row_precharge_time
// - all-select high hits every bank, else one
// - precharge of idle or precharging bank ignored
// - read/write with all-select high auto-precharges bank
// - auto precharge applies to that command only
// - auto precharge starts at earliest legal time
// - read auto precharge waits for burst data
// - write auto precharge starts after write recovery
// - internal precharge waits for row_active_time
// - commands to other banks proceed during auto precharge
// - refresh rows come from internal counter
// - refresh period lasts refresh_cycle_time from command
// - data outputs stay high impedance during refresh
module bpr_top #(
    parameter int T_RP = bpr_pkg::BPR_T_RP,
    parameter int T_RAS = bpr_pkg::BPR_T_RAS,
    parameter int T_RCD = bpr_pkg::BPR_T_RCD,
    parameter int T_WR = bpr_pkg::BPR_T_WR,
    parameter int T_RFC = bpr_pkg::BPR_T_RFC
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic I_CKE,
    input wire bpr_pkg::bpr_cmd_pins_type I_CMD,
    output logic [bpr_pkg::BPR_NUM_BANKS-1:0] O_BANK_OPEN,
    output logic [bpr_pkg::BPR_NUM_BANKS-1:0] O_BANK_PRECH,
    output logic O_REFRESH_BUSY,
    output logic O_REFRESH_STROBE,
    output logic [bpr_pkg::BPR_ROW_W-1:0] O_REFRESH_ROW,
    output logic O_DQ_OE_B
);
    import bpr_pkg::*;

    localparam int NB = BPR_NUM_BANKS;
    localparam int CW = BPR_CNT_W;
    localparam int RD_AP_CYC = BPR_BURST_CYC;
    localparam int WR_AP_CYC = BPR_BURST_CYC + 1 + T_WR;

    // refuse timings the counters cannot hold
    if (T_RP < 1 || T_RAS < 1 || T_RCD < 1 ||
        T_WR < 1 || T_RFC < 1) begin : g_min_chk
        $error("timing parameters must be at least one cycle");
    end
    if (T_RP >= (1 << CW) || T_RAS >= (1 << CW) || T_RFC >= (1 << CW) ||
        WR_AP_CYC >= (1 << CW)) begin : g_max_chk
        $error("timing parameters exceed counter width");
    end

    // two-stage synchronisers on pin inputs
    bpr_cmd_pins_type cmd_s1_q, cmd_s2_q;
    logic cke_s1_q, cke_s2_q;
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            cmd_s1_q <= '1;
            cmd_s2_q <= '1;
            cke_s1_q <= 1'b0;
            cke_s2_q <= 1'b0;
        end else begin
            cmd_s1_q <= I_CMD;
            cmd_s2_q <= cmd_s1_q;
            cke_s1_q <= I_CKE;
            cke_s2_q <= cke_s1_q;
        end
    end

    function automatic bpr_cmd_type decode(input bpr_cmd_pins_type p,
                                           input logic cke);
        bpr_cmd_type c;
        c = BPR_CMD_NOP;
        if (cke && !p.cs_n) begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h3: c = BPR_CMD_ACT;
                3'h5: c = BPR_CMD_RD;
                3'h4: c = BPR_CMD_WR;
                3'h2: c = BPR_CMD_PRE;
                3'h1: c = BPR_CMD_REF;
                default: c = BPR_CMD_NOP;
            endcase
        end
        return c;
    endfunction : decode

    bpr_cmd_type cmd;
    logic [1:0] cmd_bank;
    assign cmd = decode(cmd_s2_q, cke_s2_q);
    assign cmd_bank = {cmd_s2_q.bank_select_bit1, cmd_s2_q.bank_select_bit0};

    // refresh timer and internal row counter
    logic [CW-1:0] rfc_cnt_q, rfc_cnt_d;
    logic [BPR_ROW_W-1:0] ref_row_q, ref_row_d;
    logic ref_stb_q, ref_stb_d;
    logic ref_busy_q, ref_busy_d;
    logic [CW-1:0] ref_len_q, ref_len_d;
    always_comb begin
        rfc_cnt_d = rfc_cnt_q;
        ref_row_d = ref_row_q;
        ref_stb_d = 1'b0;
        // cycles of the running refresh period, for the length checks
        ref_len_d = ref_busy_q ? ref_len_q + 1'b1 : '0;
        if (rfc_cnt_q != '0)
            rfc_cnt_d = rfc_cnt_q - 1'b1;
        else if (cmd == BPR_CMD_REF) begin
            rfc_cnt_d = CW'(T_RFC);
            ref_row_d = ref_row_q + 1'b1;
            ref_stb_d = 1'b1;
        end
        ref_busy_d = (rfc_cnt_d != '0);
    end
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            rfc_cnt_q <= '0;
            ref_row_q <= BPR_REF_ROW_RST;
            ref_stb_q <= 1'b0;
            ref_busy_q <= 1'b0;
            ref_len_q <= '0;
        end else begin
            rfc_cnt_q <= rfc_cnt_d;
            ref_row_q <= ref_row_d;
            ref_stb_q <= ref_stb_d;
            ref_busy_q <= ref_busy_d;
            ref_len_q <= ref_len_d;
        end
    end

    // per-bank state machines
    bpr_state_type st_q [NB];
    bpr_state_type st_d [NB];
    logic [CW-1:0] ras_q [NB];
    logic [CW-1:0] ras_d [NB];
    logic [CW-1:0] tmr_q [NB];
    logic [CW-1:0] tmr_d [NB];
    logic [NB-1:0] open_q, prech_q;
    logic data_busy_d;
    logic [CW-1:0] data_cnt_q, data_cnt_d;

    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_bank
            logic hit, pre_hit;
            assign hit = (cmd_bank == 2'(b));  // per-bank decode
            // all-select widens a precharge to every bank
            assign pre_hit = (cmd == BPR_CMD_PRE) &&
                             (cmd_s2_q.precharge_all_select || hit);
            always_comb begin
                st_d[b] = st_q[b];
                ras_d[b] = (ras_q[b] != '0) ? ras_q[b] - 1'b1 : ras_q[b];
                tmr_d[b] = (tmr_q[b] != '0) ? tmr_q[b] - 1'b1 : tmr_q[b];
                case (st_q[b])
                    BPR_ST_IDLE: begin
                        // precharge of an idle bank does nothing
                        if (cmd == BPR_CMD_ACT && hit) begin
                            st_d[b] = BPR_ST_OPEN;
                            ras_d[b] = CW'(T_RAS - 1);
                        end
                    end
                    BPR_ST_OPEN: begin
                        if (pre_hit) begin
                            st_d[b] = BPR_ST_PRECH;
                            tmr_d[b] = CW'(T_RP - 1);
                        end else if ((cmd == BPR_CMD_RD || cmd == BPR_CMD_WR)
                                     && hit
                                     && cmd_s2_q.precharge_all_select) begin
                            st_d[b] = BPR_ST_AP_WAIT;
                            tmr_d[b] = (cmd == BPR_CMD_RD) ?
                                CW'(RD_AP_CYC - 1) : CW'(WR_AP_CYC - 1);
                        end
                    end
                    BPR_ST_AP_WAIT: begin
                        // wait access end and row active time
                        if (tmr_q[b] == '0 && ras_q[b] == '0) begin
                            st_d[b] = BPR_ST_PRECH;
                            tmr_d[b] = CW'(T_RP - 1);
                        end
                    end
                    BPR_ST_PRECH: begin
                        if (tmr_q[b] == '0)
                            st_d[b] = BPR_ST_IDLE;
                    end
                    default: st_d[b] = BPR_ST_IDLE;
                endcase
            end
            always_ff @(posedge I_SYS_CLK) begin
                if (!I_RST_B) begin
                    st_q[b] <= BPR_ST_IDLE;
                    ras_q[b] <= '0;
                    tmr_q[b] <= '0;
                    open_q[b] <= 1'b0;
                    prech_q[b] <= 1'b0;
                end else begin
                    st_q[b] <= st_d[b];
                    ras_q[b] <= ras_d[b];
                    tmr_q[b] <= tmr_d[b];
                    open_q[b] <= (st_d[b] == BPR_ST_OPEN) ||
                                 (st_d[b] == BPR_ST_AP_WAIT);
                    prech_q[b] <= (st_d[b] == BPR_ST_PRECH);
                end
            end

            // cycles spent in the precharge period, for the length checks
            logic [CW-1:0] ph_cnt_q, ph_cnt_d;
            always_comb begin
                ph_cnt_d = '0;
                if (st_q[b] == BPR_ST_PRECH)
                    ph_cnt_d = ph_cnt_q + 1'b1;
            end
            always_ff @(posedge I_SYS_CLK) begin
                if (!I_RST_B)
                    ph_cnt_q <= '0;
                else
                    ph_cnt_q <= ph_cnt_d;
            end

            // an explicit precharge leads to idle after T_RP cycles
            prech_len_a: assert property (@(posedge I_SYS_CLK)
                disable iff (!I_RST_B)
                (st_q[b] == BPR_ST_OPEN && pre_hit) |=>
                (st_q[b] == BPR_ST_PRECH && ph_cnt_q == '0))
                else $error("bank precharge did not start");
            prech_hold_a: assert property (@(posedge I_SYS_CLK)
                disable iff (!I_RST_B)
                (st_q[b] == BPR_ST_PRECH && ph_cnt_q < CW'(T_RP - 1)) |=>
                st_q[b] == BPR_ST_PRECH)
                else $error("bank precharge ended early");
            prech_end_a: assert property (@(posedge I_SYS_CLK)
                disable iff (!I_RST_B)
                (st_q[b] == BPR_ST_PRECH && ph_cnt_q == CW'(T_RP - 1)) |=>
                st_q[b] == BPR_ST_IDLE)
                else $error("bank precharge ended late");
            idle_pre_a: assert property (@(posedge I_SYS_CLK)
                disable iff (!I_RST_B)
                (st_q[b] == BPR_ST_IDLE && cmd != BPR_CMD_ACT) |=>
                st_q[b] == BPR_ST_IDLE)
                else $error("idle bank left idle without activate");
            ras_lock_a: assert property (@(posedge I_SYS_CLK)
                disable iff (!I_RST_B)
                (st_q[b] == BPR_ST_AP_WAIT && ras_q[b] != '0) |=>
                st_q[b] != BPR_ST_PRECH)
                else $error("auto precharge before row active time");
            ap_start_a: assert property (@(posedge I_SYS_CLK)
                disable iff (!I_RST_B)
                (st_q[b] == BPR_ST_AP_WAIT && tmr_q[b] == '0 &&
                 ras_q[b] == '0) |=> st_q[b] == BPR_ST_PRECH)
                else $error("auto precharge start late");
            ap_arm_a: assert property (@(posedge I_SYS_CLK)
                disable iff (!I_RST_B)
                (st_q[b] == BPR_ST_OPEN && hit && cmd == BPR_CMD_WR &&
                 cmd_s2_q.precharge_all_select && !pre_hit) |=>
                st_q[b] == BPR_ST_AP_WAIT)
                else $error("auto precharge not armed");
            no_ap_a: assert property (@(posedge I_SYS_CLK)
                disable iff (!I_RST_B)
                (st_q[b] == BPR_ST_OPEN && !pre_hit &&
                 !cmd_s2_q.precharge_all_select) |=>
                st_q[b] == BPR_ST_OPEN)
                else $error("auto precharge persisted");
            wr_rec_a: assert property (@(posedge I_SYS_CLK)
                disable iff (!I_RST_B)
                (st_q[b] == BPR_ST_OPEN && hit && cmd == BPR_CMD_WR &&
                 cmd_s2_q.precharge_all_select) |=>
                st_q[b] == BPR_ST_AP_WAIT [*4])
                else $error("write auto precharge before recovery");
        end
    endgenerate

    // data bus busy window for read/write bursts
    always_comb begin
        data_cnt_d = (data_cnt_q != '0) ? data_cnt_q - 1'b1 : data_cnt_q;
        data_busy_d = (data_cnt_q > CW'(1));
        if (cmd == BPR_CMD_RD || cmd == BPR_CMD_WR) begin
            data_cnt_d = CW'(BPR_CAS_LAT + BPR_BURST_CYC);
            data_busy_d = 1'b1;
        end
    end
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            data_cnt_q <= '0;
        end else begin
            data_cnt_q <= data_cnt_d;
        end
    end

    // outputs straight from flip-flops
    logic dq_oe_b_q;
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B)
            dq_oe_b_q <= 1'b1;
        else  // no drive while refreshing or without a read or write burst
            dq_oe_b_q <= !(data_busy_d && rfc_cnt_d == '0);
    end

    assign O_BANK_OPEN = open_q;
    assign O_BANK_PRECH = prech_q;
    assign O_REFRESH_BUSY = ref_busy_q;
    assign O_REFRESH_STROBE = ref_stb_q;
    assign O_REFRESH_ROW = ref_row_q;
    assign O_DQ_OE_B = dq_oe_b_q;

    rfc_len_a: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_B)
        O_REFRESH_BUSY |-> ref_len_q < CW'(T_RFC))
        else $error("refresh period too long");
    rfc_end_a: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_B)
        $fell(O_REFRESH_BUSY) |-> ref_len_q == CW'(T_RFC))
        else $error("refresh period too short");
    ref_row_a: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_B)
        O_REFRESH_STROBE |-> O_REFRESH_ROW == $past(O_REFRESH_ROW) + 1'b1)
        else $error("refresh row not advanced");
    dq_hiz_a: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_B)
        O_REFRESH_BUSY |-> O_DQ_OE_B)
        else $error("data driven during refresh");
endmodule : bpr_top
`default_nettype wire

/* hdl/bpr_pkg.sv */
// Purpose: shared constants and types for the bank precharge/refresh block
// Assumes: four banks, commands decoded from sampled command pins
// Notes: timing figures are whole clock cycles at 40 MHz
`default_nettype none
package bpr_pkg;
    localparam int BPR_NUM_BANKS = 4;
    localparam int BPR_ROW_W = 13;
    localparam int BPR_CNT_W = 8;
    localparam int BPR_T_RP = 3;
    localparam int BPR_T_RAS = 8;
    localparam int BPR_T_RCD = 3;
    localparam int BPR_T_WR = 3;
    localparam int BPR_T_RFC = 6;
    localparam int BPR_BURST_CYC = 2;
    localparam int BPR_CAS_LAT = 3;
    localparam logic [BPR_ROW_W-1:0] BPR_REF_ROW_RST = 13'h0000;
    localparam logic [1:0] BPR_BANK_ALL_IDLE = 2'h0;

    typedef enum logic [2:0] {
        BPR_CMD_NOP,
        BPR_CMD_ACT,
        BPR_CMD_RD,
        BPR_CMD_WR,
        BPR_CMD_PRE,
        BPR_CMD_REF
    } bpr_cmd_type;

    typedef enum logic [1:0] {
        BPR_ST_IDLE,
        BPR_ST_OPEN,
        BPR_ST_AP_WAIT,
        BPR_ST_PRECH
    } bpr_state_type;

    // command as presented to the device on one clock edge
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic precharge_all_select;
        logic bank_select_bit1;
        logic bank_select_bit0;
    } bpr_cmd_pins_type;
endpackage : bpr_pkg
`default_nettype wire

/* verif/bpr_ctl_model.sv */
// Purpose: memory controller model driving the command pins
// Assumes: caller waits for tasks to return before the next call
// Notes: address lines flip on each nops cycle and on the nop after a command, clock enable stays high
`default_nettype none
module bpr_ctl_model (
    input wire logic i_clk,
    output var bpr_pkg::bpr_cmd_pins_type o_cmd,
    output var logic o_cke
);
    timeunit 1ns;
    timeprecision 100ps;
    import bpr_pkg::*;
    logic [2:0] rcw;

    initial begin
        o_cke = 1'b1;
        o_cmd = 7'h7F;
    end

    // one command for one edge, then a nop
    task automatic issue(input bpr_cmd_type k, input logic [1:0] bk,
            input logic ap);
        case (k)
            BPR_CMD_ACT: rcw = 3'h3;
            BPR_CMD_RD: rcw = 3'h5;
            BPR_CMD_WR: rcw = 3'h4;
            BPR_CMD_PRE: rcw = 3'h2;
            BPR_CMD_REF: rcw = 3'h1;
            default: rcw = 3'h7;
        endcase
        @(posedge i_clk);
        #2;
        o_cmd = {1'b0, rcw, ap, bk};
        @(posedge i_clk);
        #2;
        o_cmd = {4'h7, ~ap, ~bk};
    endtask : issue

    // idle cycles keep open banks and refresh untouched
    task automatic nops(input int n);
        repeat (n) begin
            @(posedge i_clk);
            #2;
            o_cmd = {4'h7, ~o_cmd.precharge_all_select, ~o_cmd[1:0]};
        end
    endtask : nops
endmodule : bpr_ctl_model
`default_nettype wire

/* verif/tb_bank_precharge_refresh.sv */
// Purpose: self-checking bench for bank precharge and refresh
// Assumes: default timing parameters of the package
// Notes: banks drawn at random from a fixed seed
`default_nettype none
module tb_bank_precharge_refresh;
    timeunit 1ns;
    timeprecision 100ps;
    import bpr_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    bpr_cmd_pins_type cmd;
    logic cke;
    logic [3:0] open_w;
    logic [3:0] prech_w;
    logic busy;
    logic strobe;
    logic [12:0] row;
    logic oe_b;
    logic [1:0] b;
    logic [1:0] c;
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    int tc;
    int ta;
    int st;
    int ln;
    int nref = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    bpr_ctl_model i_ctl (.i_clk(clk), .o_cmd(cmd), .o_cke(cke));

    bpr_top i_dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_CKE(cke),
        .I_CMD(cmd), .O_BANK_OPEN(open_w), .O_BANK_PRECH(prech_w),
        .O_REFRESH_BUSY(busy), .O_REFRESH_STROBE(strobe),
        .O_REFRESH_ROW(row), .O_DQ_OE_B(oe_b));

    task automatic chk(input string nm, input logic [31:0] got,
            input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    task automatic results;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    function automatic int mx(input int x, input int y);
        return (x > y) ? x : y;
    endfunction : mx

    function automatic logic flag(input int m, input logic [1:0] bk);
        return (m != 0) ? busy : prech_w[bk];
    endfunction : flag

    task automatic go(input bpr_cmd_type k, input logic [1:0] bk,
            input logic ap);
        i_ctl.issue(k, bk, ap);
        tc = cyc - 1;
    endtask : go

    // start edge and length of a precharge or refresh period
    task automatic meas(input int m, input logic [1:0] bk);
        int k;
        st = -1;
        ln = 0;
        for (k = 0; k < 40 && st < 0; k++) begin
            if (flag(m, bk) === 1'b1) begin
                st = cyc;
                if (m != 0) chk("strobe", strobe, 1);
            end else begin
                @(posedge clk);
                #1;
            end
        end
        if (st < 0) begin
            num_errors++;
            $display("Error wait expected period seen none");
            results();
        end
        while (flag(m, bk) === 1'b1 && ln < 40) begin
            chk("dq_oe_b", oe_b, 1);
            ln++;
            @(posedge clk);
            #1;
        end
    endtask : meas

    initial begin
        int it;
        void'($urandom(18533));
        repeat (20) @(posedge clk);
        #2;
        rst_b = 1'b1;
        chk("open_rst", open_w, 0);
        for (it = 0; it < 4; it++) begin
            b = 2'($urandom);
            c = b + 2'(1 + $urandom % 3);
            go(BPR_CMD_ACT, b, 1'b0);
            go(BPR_CMD_ACT, c, 1'b0);
            i_ctl.nops(BPR_T_RAS);
            go(BPR_CMD_PRE, b, 1'b0);
            ta = tc;
            go(BPR_CMD_PRE, b, 1'b0);
            meas(0, b);
            chk("pre_start", st - ta, 3);
            chk("pre_len", ln, BPR_T_RP);
            chk("open_one", open_w, 32'h1 << c);
            go(BPR_CMD_PRE, b, 1'b0);
            i_ctl.nops(3);
            chk("idle_pre", prech_w[b], 0);
            go(BPR_CMD_PRE, 2'($urandom), 1'b1);
            ta = tc;
            meas(0, c);
            chk("all_start", st - ta, 3);
            chk("all_open", open_w, 0);
            go(BPR_CMD_ACT, b, 1'b0);
            ta = tc;
            i_ctl.nops(BPR_T_RCD - 2);
            go(BPR_CMD_RD, b, 1'b1);
            go(BPR_CMD_ACT, c, 1'b0);
            meas(0, b);
            chk("rd_ap", st - ta, 3 + mx(BPR_T_RAS,
                BPR_T_RCD + BPR_BURST_CYC));
            chk("rd_ap_len", ln, BPR_T_RP);
            chk("other", open_w[c], 1);
            go(BPR_CMD_ACT, b, 1'b0);
            ta = tc;
            i_ctl.nops(BPR_T_RCD - 2);
            go(BPR_CMD_WR, b, 1'b1);
            meas(0, b);
            chk("wr_ap", st - ta, 3 + mx(BPR_T_RAS,
                BPR_T_RCD + BPR_BURST_CYC + 1 + BPR_T_WR));
            go(BPR_CMD_ACT, b, 1'b0);
            i_ctl.nops(BPR_T_RCD - 2);
            go(BPR_CMD_RD, b, 1'b0);
            i_ctl.nops(20);
            chk("no_ap", {open_w[b], prech_w[b]}, 2);
            go(BPR_CMD_PRE, 2'($urandom), 1'b1);
            i_ctl.nops(BPR_T_RP + 3);
            repeat (2) begin
                go(BPR_CMD_REF, 2'($urandom), 1'($urandom));
                ta = tc;
                meas(1, 2'h0);
                nref++;
                chk("ref_start", st - ta, 3);
                chk("ref_len", ln, BPR_T_RFC);
                chk("ref_row", row, nref);
            end
            $display("test %0d done", it);
        end
        results();
    end
endmodule : tb_bank_precharge_refresh
`default_nettype wire
